/* File: csp_stage_prox_ctrl.sv */
// Purpose: stage sequencer, wake timing, input routing and proximity calibration control
// Assumes: converter result on cdc_data is valid in the last cycle of each stage
// Notes: registers reached over a plain word-addressed read/write port
//
// Contract
// [RULE_01] low power wake spacing comes from power control bits 3:2
// [RULE_02] wake delay codes 00..11 give 200, 400, 600, 800 ms
// [RULE_03] low power period is full power sequence time plus wake delay
// [RULE_04] raw 16-bit converter result readable at word 0x00B
// [RULE_05] each stage applies its own routing, offset, sensitivity, limit words
// [RULE_06] each input routes to positive, negative, bias or floating per stage
// [RULE_07] two-bit route code per input per stage
// [RULE_08] positive route raises code, negative lowers it
// [RULE_09] match field 13:12: none, single positive, single negative, differential
// [RULE_10] host sets match to differential when inputs share a terminal
// [RULE_11] host routes unused inputs to bias
// [RULE_12] proximity watched on all stages; calibration stops at once
// [RULE_13] after proximity clears calibration stays off for hold period
// [RULE_14] full power hold is count times 16 sequences
// [RULE_15] low power hold is count times 4 sequences
// [RULE_16] ambient tracking suspended while proximity flag set
// [RULE_17] forced recalibration after exceeding ambient for whole timeout
// [RULE_18] full power timeout is count times full power sequences
// [RULE_19] low power timeout is count times low power sequences
// [RULE_20] recalibration happens however long proximity lasts
// [RULE_21] recalibration level 0x003 bits 7:0, times 16 is threshold
// [RULE_22] hold counts at 0x002 bits 7:4 and 11:8
// [RULE_23] timeout counts at 0x004 bits 9:0 and 15:10
// [RULE_24] recalibration loads current result as ambient and clears counter
`timescale 1ns/1ps
`include "csp_map.svh"

module csp_stage_prox_ctrl #(
  parameter int STAGE_CYC = `CSP_STAGE_TIME_NS / `CSP_CLK_PERIOD_NS,
  parameter int WAKE_STEP_CYC = `CSP_WAKE_STEP_MS * 1000000 / `CSP_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register port
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // converter side
  input wire logic [15:0] cdc_data,
  output logic stage_start,
  output logic [3:0] conv_stage,
  output logic [25:0] stage_route,
  output logic [1:0] stage_match,
  output logic [15:0] stage_offset,
  output logic [15:0] stage_sens,
  output logic [15:0] stage_limit,
  output logic route_err,
  // status
  output logic seq_done,
  output logic prox_flag,
  output logic cal_enable,
  output logic recal_pulse
);

  function automatic logic [15:0] csp_absdiff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [3:0] csp_count_code(input logic [25:0] r, input logic [1:0] c);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 13; i++) begin
      if (r[2*i +: 2] == c) n = n + 4'h1;
    end
    return n;
  endfunction

  function automatic logic [16:0] csp_stage_cycles(input logic [1:0] dec);
    case (dec)
      2'b00: return 17'(STAGE_CYC * 4);
      2'b01: return 17'(STAGE_CYC * 2);
      default: return 17'(STAGE_CYC);
    endcase
  endfunction

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  logic [15:0] pwr_ff, calhold_ff, lvl_ff, tmo_ff, raw_ff, rdata_ff;
  logic [15:0] cfg_ff [`CSP_CFG_WORDS];
  logic [15:0] amb_ff [`CSP_STAGES];
  logic [9:0] recal_cnt_ff [`CSP_STAGES];
  logic [11:0] stage_prox_ff, nxt_stage_prox;
  // a stage has no ambient until its first result after reset
  logic [11:0] seeded_ff;
  csp_pkg::csp_state_t state_ff, nxt_state;
  logic [3:0] stage_ff, nxt_stage, conv_stage_ff, recal_stage_ff;
  logic [16:0] tmr_ff, nxt_tmr;
  logic [24:0] wake_ff, nxt_wake;
  logic [7:0] hold_ff, nxt_hold, hold_load;
  logic [25:0] route_ff;
  logic [1:0] match_ff;
  logic [15:0] offset_ff, sens_ff, limit_ff;
  logic start_ff, nxt_start, done_ff, nxt_done, route_err_ff, prox_ff, nxt_prox, cal_en_ff, recal_ff;
  logic is_low, is_off, stage_end, exceed, recal_hit;
  logic [3:0] last_stage;
  logic [9:0] recal_lim;
  logic [6:0] nb;

  assign is_low = pwr_ff[`CSP_PWR_MODE] == csp_pkg::CSP_PWR_LOW;
  assign is_off = pwr_ff[0];
  assign last_stage = (pwr_ff[`CSP_SEQ_LAST] > `CSP_LAST_STAGE) ? `CSP_LAST_STAGE : pwr_ff[`CSP_SEQ_LAST];
  assign stage_end = (state_ff == csp_pkg::CSP_ST_CONV) && (tmr_ff <= 17'h00001);

  // register writes
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pwr_ff <= `CSP_PWR_RST;
      calhold_ff <= `CSP_CALHOLD_RST;
      lvl_ff <= `CSP_LVL_RST;
      tmo_ff <= `CSP_TMO_RST;
      for (int i = 0; i < `CSP_CFG_WORDS; i++) cfg_ff[i] <= `CSP_CFG_RST;
    end else if (reg_wr) begin
      if (reg_addr == `CSP_ADR_PWR) begin
        pwr_ff <= reg_wdata;
      end else if (reg_addr == `CSP_ADR_CALHOLD) begin
        calhold_ff <= reg_wdata; // RULE_22
      end else if (reg_addr == `CSP_ADR_RECAL_LVL) begin
        lvl_ff <= reg_wdata; // RULE_21
      end else if (reg_addr == `CSP_ADR_RECAL_TMO) begin
        tmo_ff <= reg_wdata; // RULE_23
      end else if (reg_addr[9:7] == `CSP_ADR_CFG_HI && reg_addr[6:0] < 7'(`CSP_CFG_WORDS)) begin
        cfg_ff[reg_addr[6:0]] <= reg_wdata; // RULE_05
      end
    end
  end

  // register reads, answered one cycle after reg_rd
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `CSP_ADR_PWR) begin
        rdata_ff <= pwr_ff;
      end else if (reg_addr == `CSP_ADR_CALHOLD) begin
        rdata_ff <= calhold_ff;
      end else if (reg_addr == `CSP_ADR_RECAL_LVL) begin
        rdata_ff <= lvl_ff;
      end else if (reg_addr == `CSP_ADR_RECAL_TMO) begin
        rdata_ff <= tmo_ff;
      end else if (reg_addr == `CSP_ADR_STATUS) begin
        rdata_ff <= {12'h000, cal_en_ff, prox_ff, state_ff};
      end else if (reg_addr == `CSP_ADR_STAGE_PROX) begin
        rdata_ff <= {4'h0, stage_prox_ff};
      end else if (reg_addr == `CSP_ADR_RAW) begin
        rdata_ff <= raw_ff; // RULE_04
      end else if (reg_addr[9:7] == `CSP_ADR_CFG_HI && reg_addr[6:0] < 7'(`CSP_CFG_WORDS)) begin
        rdata_ff <= cfg_ff[reg_addr[6:0]];
      end else if (reg_addr[9:4] == `CSP_ADR_AMB_HI && reg_addr[3:0] <= `CSP_LAST_STAGE) begin
        rdata_ff <= amb_ff[reg_addr[3:0]];
      end else begin
        rdata_ff <= 16'h0000;
      end
    end
  end

  // sequencer: stages, then wake delay in low power
  always_comb begin
    nxt_state = state_ff;
    nxt_stage = stage_ff;
    nxt_tmr = tmr_ff;
    nxt_wake = wake_ff;
    nxt_start = 1'b0;
    nxt_done = 1'b0;
    case (state_ff)
      csp_pkg::CSP_ST_OFF: begin
        if (!is_off) begin
          nxt_state = csp_pkg::CSP_ST_CONV;
          nxt_stage = 4'h0;
          nxt_tmr = csp_stage_cycles(pwr_ff[`CSP_DECIM]);
          nxt_start = 1'b1;
        end
      end
      csp_pkg::CSP_ST_CONV: begin
        if (tmr_ff > 17'h00001) begin
          nxt_tmr = tmr_ff - 17'h00001;
        end else if (stage_ff >= last_stage) begin
          nxt_done = 1'b1;
          nxt_stage = 4'h0;
          if (is_off) begin
            nxt_state = csp_pkg::CSP_ST_OFF;
          end else if (is_low) begin
            nxt_state = csp_pkg::CSP_ST_WAKE; // RULE_03
            nxt_wake = 25'(WAKE_STEP_CYC * (int'(pwr_ff[`CSP_WAKE_SEL]) + 1)); // RULE_01 RULE_02
          end else begin
            nxt_tmr = csp_stage_cycles(pwr_ff[`CSP_DECIM]);
            nxt_start = 1'b1;
          end
        end else begin
          nxt_stage = stage_ff + 4'h1;
          nxt_tmr = csp_stage_cycles(pwr_ff[`CSP_DECIM]);
          nxt_start = 1'b1;
        end
      end
      csp_pkg::CSP_ST_WAKE: begin
        if (wake_ff > 25'h0000001) begin
          nxt_wake = wake_ff - 25'h0000001;
        end else begin
          nxt_state = is_off ? csp_pkg::CSP_ST_OFF : csp_pkg::CSP_ST_CONV;
          nxt_tmr = csp_stage_cycles(pwr_ff[`CSP_DECIM]);
          nxt_start = !is_off;
        end
      end
      default: nxt_state = csp_pkg::CSP_ST_OFF;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_ff <= csp_pkg::CSP_ST_OFF;
      stage_ff <= 4'h0;
      tmr_ff <= 17'h00000;
      wake_ff <= 25'h0000000;
      start_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      stage_ff <= nxt_stage;
      tmr_ff <= nxt_tmr;
      wake_ff <= nxt_wake;
      start_ff <= nxt_start;
      done_ff <= nxt_done;
    end
  end

  // per-stage settings presented to the front end
  assign nb = {nxt_stage, 3'b000};
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      conv_stage_ff <= 4'h0;
      route_ff <= 26'h0000000;
      match_ff <= csp_pkg::CSP_MT_NONE;
      offset_ff <= 16'h0000;
      sens_ff <= 16'h0000;
      limit_ff <= 16'h0000;
      route_err_ff <= 1'b0;
    end else if (nxt_start) begin
      conv_stage_ff <= nxt_stage;
      route_ff <= {cfg_ff[nb + 7'h01][11:0], cfg_ff[nb][13:0]}; // RULE_06 RULE_07
      match_ff <= cfg_ff[nb + 7'h01][`CSP_MATCH]; // RULE_09
      offset_ff <= cfg_ff[nb + 7'h02]; // RULE_05
      sens_ff <= cfg_ff[nb + 7'h03];
      limit_ff <= cfg_ff[nb + 7'h04];
      // flags a match setting that cannot pair the terminals
      route_err_ff <= (cfg_ff[nb + 7'h01][`CSP_MATCH] == csp_pkg::CSP_MT_NONE) ||
        ((csp_count_code({cfg_ff[nb + 7'h01][11:0], cfg_ff[nb][13:0]}, csp_pkg::CSP_RT_POS) > 4'h1 ||
          csp_count_code({cfg_ff[nb + 7'h01][11:0], cfg_ff[nb][13:0]}, csp_pkg::CSP_RT_NEG) > 4'h1) &&
         cfg_ff[nb + 7'h01][`CSP_MATCH] != csp_pkg::CSP_MT_DIFF); // RULE_09
    end
  end

  // magnitude compare: positive and negative routes move the code either way
  // unseeded stage never reads as proximity, else a zero ambient locks the flag on
  assign exceed = seeded_ff[stage_ff] &&
    (csp_absdiff(cdc_data, amb_ff[stage_ff]) > {4'h0, lvl_ff[`CSP_LVL], 4'h0}); // RULE_08 RULE_21
  assign recal_lim = is_low ? {4'h0, tmo_ff[`CSP_LP_RECAL]} : tmo_ff[`CSP_FP_RECAL]; // RULE_18 RULE_19
  assign recal_hit = exceed && recal_lim != 10'h000 &&
    (10'(recal_cnt_ff[stage_ff] + 10'h001) >= recal_lim); // RULE_17 RULE_20

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      raw_ff <= 16'h0000;
      recal_ff <= 1'b0;
      recal_stage_ff <= 4'h0;
      seeded_ff <= 12'h000;
      for (int i = 0; i < `CSP_STAGES; i++) begin
        amb_ff[i] <= 16'h0000;
        recal_cnt_ff[i] <= 10'h000;
      end
    end else begin
      recal_ff <= stage_end && recal_hit;
      if (stage_end) begin
        raw_ff <= cdc_data; // RULE_04
        recal_stage_ff <= stage_ff;
        seeded_ff[stage_ff] <= 1'b1;
        if (recal_hit) begin
          amb_ff[stage_ff] <= cdc_data; // RULE_24
          recal_cnt_ff[stage_ff] <= 10'h000;
        end else begin
          if ((cal_en_ff || !seeded_ff[stage_ff]) && !exceed) amb_ff[stage_ff] <= cdc_data; // RULE_16
          recal_cnt_ff[stage_ff] <= exceed ? 10'(recal_cnt_ff[stage_ff] + 10'h001) : 10'h000;
        end
      end
    end
  end

  // proximity and calibration hold-off
  always_comb begin
    nxt_stage_prox = stage_prox_ff;
    if (stage_end) nxt_stage_prox[stage_ff] = exceed && !recal_hit; // RULE_12
    nxt_prox = |nxt_stage_prox;
    hold_load = is_low ? {2'b00, calhold_ff[`CSP_LP_HOLD], 2'b00} : {calhold_ff[`CSP_FP_HOLD], 4'h0}; // RULE_14 RULE_15
    nxt_hold = hold_ff;
    if (nxt_prox) begin
      nxt_hold = 8'h00;
    end else if (prox_ff) begin
      nxt_hold = hold_load; // RULE_13
    end else if (done_ff && hold_ff != 8'h00) begin
      nxt_hold = hold_ff - 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stage_prox_ff <= 12'h000;
      prox_ff <= 1'b0;
      hold_ff <= 8'h00;
      cal_en_ff <= 1'b1;
    end else begin
      stage_prox_ff <= nxt_stage_prox;
      prox_ff <= nxt_prox;
      hold_ff <= nxt_hold;
      cal_en_ff <= !nxt_prox && nxt_hold == 8'h00; // RULE_12 RULE_13
    end
  end

  property p_wake_load;
    $rose(state_ff == csp_pkg::CSP_ST_WAKE) |->
      wake_ff == 25'(WAKE_STEP_CYC * (int'($past(pwr_ff[`CSP_WAKE_SEL])) + 1));
  endproperty
  a_wake_load: assert property (p_wake_load) else $error("wake delay load wrong"); // RULE_02

  property p_wake_end;
    (state_ff == csp_pkg::CSP_ST_WAKE && wake_ff == 25'h0000001 && !is_off) |=>
      (state_ff == csp_pkg::CSP_ST_CONV && start_ff && conv_stage_ff == 4'h0);
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("no sequence after wake delay"); // RULE_03

  property p_raw;
    stage_end |=> raw_ff == $past(cdc_data);
  endproperty
  a_raw: assert property (p_raw) else $error("raw result not captured"); // RULE_04

  property p_cfg;
    (start_ff && !$past(reg_wr)) |-> stage_offset == cfg_ff[{conv_stage_ff, 3'b010}] &&
      stage_match == cfg_ff[{conv_stage_ff, 3'b001}][`CSP_MATCH];
  endproperty
  a_cfg: assert property (p_cfg) else $error("stage settings not applied"); // RULE_05

  property p_prox_cal;
    prox_ff |-> !cal_en_ff;
  endproperty
  a_prox_cal: assert property (p_prox_cal) else $error("calibration on during proximity"); // RULE_12

  property p_hold;
    $fell(prox_ff) |-> hold_ff == $past(hold_load) && (cal_en_ff == (hold_ff == 8'h00));
  endproperty
  a_hold: assert property (p_hold) else $error("hold period not loaded"); // RULE_13

  property p_amb_freeze;
    (stage_end && prox_ff && !recal_hit && seeded_ff[stage_ff]) |=>
      amb_ff[$past(stage_ff)] == $past(amb_ff[stage_ff]);
  endproperty
  a_amb_freeze: assert property (p_amb_freeze) else $error("ambient moved during proximity"); // RULE_16

  property p_recal;
    recal_ff |-> amb_ff[recal_stage_ff] == raw_ff && recal_cnt_ff[recal_stage_ff] == 10'h000;
  endproperty
  a_recal: assert property (p_recal) else $error("recalibration did not reload ambient"); // RULE_24

  c_wake: cover property ($rose(state_ff == csp_pkg::CSP_ST_WAKE));
  c_recal: cover property (recal_ff);
  c_reenable: cover property ($rose(cal_en_ff));

  assign reg_rdata = rdata_ff;
  assign stage_start = start_ff;
  assign conv_stage = conv_stage_ff;
  assign stage_route = route_ff;
  assign stage_match = match_ff;
  assign stage_offset = offset_ff;
  assign stage_sens = sens_ff;
  assign stage_limit = limit_ff;
  assign route_err = route_err_ff;
  assign seq_done = done_ff;
  assign prox_flag = prox_ff;
  assign cal_enable = cal_en_ff;
  assign recal_pulse = recal_ff;

endmodule

/* File: csp_map.svh */
// Purpose: register offsets, field positions, reset values and timing figures
// Assumes: word-addressed register port, 25 MHz sys_clk
// Notes: definitions only
`ifndef CSP_MAP_SVH
`define CSP_MAP_SVH

`define CSP_ADR_PWR 10'h000
`define CSP_ADR_CALHOLD 10'h002
`define CSP_ADR_RECAL_LVL 10'h003
`define CSP_ADR_RECAL_TMO 10'h004
`define CSP_ADR_STATUS 10'h008
`define CSP_ADR_STAGE_PROX 10'h009
`define CSP_ADR_RAW 10'h00B
`define CSP_ADR_CFG_HI 3'h1
`define CSP_ADR_AMB_HI 6'h0E

`define CSP_PWR_MODE 1:0
`define CSP_WAKE_SEL 3:2
`define CSP_SEQ_LAST 7:4
`define CSP_DECIM 9:8
`define CSP_FP_HOLD 7:4
`define CSP_LP_HOLD 11:8
`define CSP_LVL 7:0
`define CSP_FP_RECAL 9:0
`define CSP_LP_RECAL 15:10
`define CSP_MATCH 13:12

`define CSP_PWR_RST 16'h0001
`define CSP_CALHOLD_RST 16'h0000
`define CSP_LVL_RST 16'h0000
`define CSP_TMO_RST 16'h0000
`define CSP_CFG_RST 16'h0000

`define CSP_STAGES 12
`define CSP_CFG_WORDS 96
`define CSP_LAST_STAGE 4'hB
`define CSP_CLK_PERIOD_NS 40
`define CSP_STAGE_TIME_NS 768000
`define CSP_WAKE_STEP_MS 200

`endif

/* File: csp_pkg.sv */
// Purpose: shared types of the stage sequencer and proximity logic
// Assumes: nothing
// Notes: encodings of mode and routing codes
package csp_pkg;
  typedef enum logic [1:0] {
    CSP_ST_OFF = 2'b00,
    CSP_ST_CONV = 2'b01,
    CSP_ST_WAKE = 2'b10
  } csp_state_t;

  typedef enum logic [1:0] {
    CSP_PWR_FULL = 2'b00,
    CSP_PWR_OFF = 2'b01,
    CSP_PWR_LOW = 2'b10,
    CSP_PWR_OFF2 = 2'b11
  } csp_pwr_t;

  typedef enum logic [1:0] {
    CSP_RT_FLOAT = 2'b00,
    CSP_RT_NEG = 2'b01,
    CSP_RT_POS = 2'b10,
    CSP_RT_BIAS = 2'b11
  } csp_route_t;

  typedef enum logic [1:0] {
    CSP_MT_NONE = 2'b00,
    CSP_MT_SE_POS = 2'b01,
    CSP_MT_SE_NEG = 2'b10,
    CSP_MT_DIFF = 2'b11
  } csp_match_t;
endpackage

/* File: csp_sensor_model.sv */
// Purpose: electrode and converter stand-in that feeds averaged results to the block
// Assumes: each touched electrode on a positive or negative route moves the result by DELTA codes
// Notes: bias and floating inputs contribute nothing
`timescale 1ns/1ps

module csp_sensor_model #(
  parameter logic [15:0] BASE = 16'h8000,
  parameter logic [15:0] DELTA = 16'h0040
) (
  // routing of the running stage
  input wire logic [25:0] stage_route,
  // electrodes the user is near
  input wire logic [12:0] touch,
  // averaged result
  output logic [15:0] cdc_data
);
  always_comb begin
    cdc_data = BASE;
    for (int n = 0; n < 13; n++) begin
      if (touch[n] && stage_route[2*n +: 2] == csp_pkg::CSP_RT_POS) begin
        cdc_data = cdc_data + DELTA;
      end else if (touch[n] && stage_route[2*n +: 2] == csp_pkg::CSP_RT_NEG) begin
        cdc_data = cdc_data - DELTA;
      end
    end
  end
endmodule

/* File: tb_top.sv */
// Purpose: self-checking bench for the stage sequencer and proximity control
// Assumes: STAGE_CYC 4 and WAKE_STEP_CYC 10, decimation 1x so a stage is 4 cycles
// Notes: host writes and reads go over the plain word register port
`timescale 1ns/1ps
`include "csp_map.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module tb_top;
  localparam int SC = 4;
  localparam int WS = 10;
  localparam logic [15:0] BASE = 16'h8000;
  localparam logic [15:0] D = 16'h0040;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, cdc_data, stage_offset, stage_sens, stage_limit;
  logic stage_start, route_err, seq_done, prox_flag, cal_enable, recal_pulse;
  logic [3:0] conv_stage;
  logic [25:0] stage_route;
  logic [1:0] stage_match;
  logic [12:0] touch = 13'h0000;
  int num_errors = 0;
  int n_tests = 0;
  int cyc, nsd;
  logic [15:0] k0s [7] = '{16'hFFFC, 16'hFFFD, 16'hFFFE, 16'hFFFF, 16'hFFBE, 16'hFFBE, 16'hFFFE};
  logic [15:0] k1s [7] = '{16'h1FFF, 16'h2FFF, 16'h1FFF, 16'h0FFF, 16'h1FFF, 16'h3FFF, 16'h37FF};
  logic errs [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [15:0] raws [7] = '{BASE, BASE - D, BASE + D, BASE, BASE + 2*D, BASE + 2*D, BASE};

  always #20 sys_clk = ~sys_clk;

  csp_stage_prox_ctrl #(.STAGE_CYC(SC), .WAKE_STEP_CYC(WS)) csp_stage_prox_ctrl_i (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cdc_data(cdc_data), .stage_start(stage_start),
    .conv_stage(conv_stage), .stage_route(stage_route), .stage_match(stage_match),
    .stage_offset(stage_offset), .stage_sens(stage_sens), .stage_limit(stage_limit),
    .route_err(route_err), .seq_done(seq_done), .prox_flag(prox_flag), .cal_enable(cal_enable),
    .recal_pulse(recal_pulse));

  csp_sensor_model #(.BASE(BASE), .DELTA(D)) csp_sensor_model_i (
    .stage_route(stage_route), .touch(touch), .cdc_data(cdc_data));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data lands on the taking edge, so look just after it
  task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, exp, reg_rdata)
  endtask

  // bounded wait; counts seq_done pulses seen before the event
  task automatic wait_for(input int sel, output int c, output int ns);
    logic hit;
    c = 0;
    ns = 0;
    hit = 1'b0;
    while (!hit && c < 3000) begin
      @(posedge sys_clk);
      #1;
      c++;
      case (sel)
        0: hit = (stage_start === 1'b1);
        1: hit = (seq_done === 1'b1);
        2: hit = (prox_flag === 1'b1);
        3: hit = (prox_flag === 1'b0);
        4: hit = (cal_enable === 1'b1);
        default: hit = (recal_pulse === 1'b1);
      endcase
      if (!hit && seq_done === 1'b1) ns++;
    end
    if (!hit) begin
      num_errors++;
      $display("[FAIL] wait %0d ran out", sel);
      give_verdict();
    end
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    `CHK("cal_enable rst", 1'b1, cal_enable)
    `CHK("prox rst", 1'b0, prox_flag)
    rd_chk(`CSP_ADR_PWR, `CSP_PWR_RST, "pwr rst");
    rd_chk(`CSP_ADR_CALHOLD, `CSP_CALHOLD_RST, "hold rst");
    rd_chk(`CSP_ADR_RECAL_LVL, `CSP_LVL_RST, "lvl rst");
    rd_chk(`CSP_ADR_RECAL_TMO, `CSP_TMO_RST, "tmo rst");
    rd_chk(10'h3FF, 16'h0000, "unmapped");
    wr(`CSP_ADR_CALHOLD, 16'h0010);
    wr(`CSP_ADR_RECAL_LVL, 16'h00FF);
    wr(`CSP_ADR_RECAL_TMO, 16'h0000);
    rd_chk(`CSP_ADR_CALHOLD, 16'h0010, "hold rw");
    rd_chk(`CSP_ADR_RECAL_LVL, 16'h00FF, "lvl rw");
    $display("test registers done");

    // stage 0 words, full power, one stage, fastest decimation
    wr(10'h082, 16'h1111);
    wr(10'h083, 16'h2222);
    wr(10'h084, 16'h3333);
    wr(`CSP_ADR_PWR, 16'h0200);
    touch <= 13'h1FFF;
    for (int i = 0; i < 7; i++) begin
      // host keeps unused inputs on bias, except in0 floating in case 0; cases 3 and 4 set match none and a shared terminal without differential
      wr(10'h080, k0s[i]);
      wr(10'h081, k1s[i]);
      wait_for(0, cyc, nsd);
      wait_for(0, cyc, nsd);
      `CHK("stage", 4'h0, conv_stage)
      `CHK("route", {k1s[i][11:0], k0s[i][13:0]}, stage_route)
      `CHK("match", k1s[i][13:12], stage_match)
      `CHK("route_err", errs[i], route_err)
      `CHK("offset", 16'h1111, stage_offset)
      `CHK("sens", 16'h2222, stage_sens)
      `CHK("limit", 16'h3333, stage_limit)
      wait_for(1, cyc, nsd);
      rd_chk(`CSP_ADR_RAW, raws[i], "raw");
    end
    `CHK("fp period", SC, cyc)
    $display("test routing done");

    wr(`CSP_ADR_PWR, 16'h0210);
    wait_for(0, cyc, nsd);
    wait_for(1, cyc, nsd);
    wait_for(1, cyc, nsd);
    `CHK("two stage seq", 2 * SC, cyc)
    for (int w = 0; w < 4; w++) begin
      wr(`CSP_ADR_PWR, 16'h0202 | 16'(w << 2));
      wait_for(0, cyc, nsd);
      wait_for(0, cyc, nsd);
      wait_for(0, cyc, nsd);
      `CHK("lp period", SC + WS * (w + 1), cyc)
    end
    $display("test wake done");

    // in0 only on positive, one touch moves D = 64 above the 32 code level
    wr(`CSP_ADR_PWR, 16'h0200);
    wr(10'h080, 16'hFFFE);
    wr(10'h081, 16'h1FFF);
    touch <= 13'h0000;
    wr(`CSP_ADR_RECAL_LVL, 16'h0002);
    repeat (3) wait_for(1, cyc, nsd);
    rd_chk(10'h0E0, BASE, "amb idle");
    touch <= 13'h0001;
    wait_for(2, cyc, nsd);
    `CHK("prox fast", 1'b1, (cyc <= 2 * SC + 2))
    `CHK("cal off", 1'b0, cal_enable)
    repeat (3) wait_for(1, cyc, nsd);
    rd_chk(10'h0E0, BASE, "amb frozen");
    touch <= 13'h0000;
    wait_for(3, cyc, nsd);
    `CHK("cal held", 1'b0, cal_enable)
    wait_for(4, cyc, nsd);
    `CHK("hold seqs", 1'b1, (nsd >= 15 && nsd <= 16))
    $display("test hold done");

    wr(`CSP_ADR_RECAL_TMO, 16'h0003);
    wait_for(1, cyc, nsd);
    touch <= 13'h0001;
    wait_for(5, cyc, nsd);
    `CHK("recal seqs", 1'b1, (nsd >= 2 && nsd <= 3))
    rd_chk(10'h0E0, BASE + D, "amb recal");
    wait_for(3, cyc, nsd);
    `CHK("prox gone", 1'b0, prox_flag)
    $display("test recal done");
    give_verdict();
  end
endmodule
